// >>> ctw_regs.svh
// Register indices, field positions, reset values and step sizes
`ifndef CTW_REGS_SVH
`define CTW_REGS_SVH
//**********************************************************************
// Overview of operation
// - Count arbitration-phase errors in eight bits
// - Reset mode clears arbitration error count
// - Transmit disconnect holds transmit pin recessive
// - Connected pin shows loopback frames too
// - Loopback ignores receive pin, routes transmit
// - Test bits writable only in reset mode
// - Wake-up tick period is divisor plus one
// - Activity valid once count reaches filter
// - Filter and expire writable only in reset
// - Wake-up valid only below expire time
// - Report receive FIFO bytes, multiple of four
// - Reset mode clears receive byte count
// - A receive data read without a push lowers a nonzero count
//**********************************************************************
// Register indices (word address on the bus)
`define CTW_IDX_APERR 6'h27
`define CTW_IDX_TEST 6'h28
`define CTW_IDX_WDIV 6'h29
`define CTW_IDX_WFT 6'h2a
`define CTW_IDX_WET 6'h2c
`define CTW_IDX_RXCNT 6'h30
`define CTW_IDX_CTRL 6'h38
`define CTW_IDX_ISTS 6'h39
`define CTW_IDX_IMASK 6'h3a
// Field positions
`define CTW_TEST_LBEN 0
`define CTW_TEST_TXC 1
`define CTW_CTRL_RST 0
// Reset values and steps
`define CTW_CTRL_RESET 1'b1
`define CTW_APERR_MAX 8'hff
`define CTW_RX_STEP 16'h0004
`define CTW_WET_W 20
`endif

// >>> ctw_pkg.sv
// Types shared by the test, wake-up and counter block
package ctw_pkg;
   typedef struct packed {
      logic txc;
      logic lben;
   } ctw_test_t;
   typedef struct packed {
      logic expire;
      logic wake;
      logic aperr;
   } ctw_irq_t;
   typedef enum logic [0:0] {
      W_IDLE = 1'b0,
      W_DOM = 1'b1
   } ctw_wstate_t;
endpackage : ctw_pkg

// >>> ctw_top.sv
// Test register, wake-up detector and error/byte counters
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ctw_regs.svh"
module ctw_top #(
   parameter int CNT_W = 16
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic arb_err,
   input wire logic core_tx,
   output logic core_rx,
   output logic can_tx,
   input wire logic can_rx,
   input wire logic rx_push,
   input wire logic rx_read,
   output logic wake_active,
   output logic wake_event,
   output logic reset_mode,
   output ctw_pkg::ctw_test_t test_mode,
   output logic irq
);
   import ctw_pkg::*;

   //*******************************************************************
   // Reset and bus slave
   //*******************************************************************
   logic rst_meta;
   logic rst_n;
   logic done;
   logic req;
   logic wr_en;
   logic [7:0] aperr;
   logic [7:0] wdiv;
   logic [15:0] wft;
   logic [`CTW_WET_W-1:0] wet;
   logic [`CTW_WET_W-1:0] wcnt;
   logic [CNT_W-1:0] rxcnt;
   ctw_irq_t ists;
   ctw_irq_t imask;
   ctw_irq_t ev;
   ctw_wstate_t wstate;
   logic tick;
   logic [7:0] pre;

   // Release reset through two flops
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   function automatic logic hit(input logic [5:0] a, input logic [5:0] i);
      hit = (a == i);
   endfunction : hit

   // One wait state: answer lands on the second edge of a request
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~done;
   assign wr_en = avs_write & done;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         done <= 1'b0;
      else
         done <= req & ~done;
   end

   // Read data captured in the wait cycle; unmapped reads give zero
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0;
      else if (avs_read & ~done)
      begin
         case (avs_address)
            `CTW_IDX_APERR: avs_readdata <= {24'h0, aperr};
            `CTW_IDX_TEST: avs_readdata <= {30'h0, test_mode};
            `CTW_IDX_WDIV: avs_readdata <= {24'h0, wdiv};
            `CTW_IDX_WFT: avs_readdata <= {16'h0, wft};
            `CTW_IDX_WET: avs_readdata <= {12'h0, wet};
            `CTW_IDX_RXCNT: avs_readdata <= 32'(rxcnt);
            `CTW_IDX_CTRL: avs_readdata <= {31'h0, reset_mode};
            `CTW_IDX_ISTS: avs_readdata <= {29'h0, ists};
            `CTW_IDX_IMASK: avs_readdata <= {29'h0, imask};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   //*******************************************************************
   // Control and configuration registers
   //*******************************************************************
   // Reset-mode bit; starts set so configuration can be loaded
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         reset_mode <= `CTW_CTRL_RESET;
      else if (wr_en && hit(avs_address, `CTW_IDX_CTRL))
         reset_mode <= avs_writedata[`CTW_CTRL_RST];
   end

   // Test bits locked outside reset mode
   // reset-mode write gate
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         test_mode <= '0;
      else if (wr_en && hit(avs_address, `CTW_IDX_TEST) && reset_mode)
      begin
         test_mode.txc <= avs_writedata[`CTW_TEST_TXC];
         test_mode.lben <= avs_writedata[`CTW_TEST_LBEN];
      end
   end

   // Divisor is free to change at any time
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         wdiv <= 8'h0;
      else if (wr_en && hit(avs_address, `CTW_IDX_WDIV))
         wdiv <= avs_writedata[7:0];
   end

   // Thresholds locked outside reset mode
   // reset-mode write gate
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wft <= 16'h0;
         wet <= '0;
      end
      else if (wr_en && reset_mode)
      begin
         if (hit(avs_address, `CTW_IDX_WFT))
            wft <= avs_writedata[15:0];
         if (hit(avs_address, `CTW_IDX_WET))
            wet <= avs_writedata[`CTW_WET_W-1:0];
      end
   end

   //*******************************************************************
   // Pin routing
   //*******************************************************************
   // Registered so the pins never see a glitch from the mux
   // disconnect and loopback
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         can_tx <= 1'b1;
         core_rx <= 1'b1;
      end
      else
      begin
         can_tx <= test_mode.txc ? 1'b1 : core_tx;
         core_rx <= test_mode.lben ? core_tx : can_rx;
      end
   end

   //*******************************************************************
   // Counters
   //*******************************************************************
   // clear, count, saturate
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         aperr <= 8'h0;
      else if (reset_mode)
         aperr <= 8'h0;
      else if (arb_err && aperr != `CTW_APERR_MAX)
         aperr <= aperr + 8'h1;
   end

   // Whole words only, so the count stays a multiple of four
   // byte count
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rxcnt <= '0;
      else if (reset_mode)
         rxcnt <= '0;
      else if (rx_push && !rx_read)
         rxcnt <= rxcnt + CNT_W'(`CTW_RX_STEP);
      else if (rx_read && !rx_push && rxcnt != '0)
         rxcnt <= rxcnt - CNT_W'(`CTW_RX_STEP);
   end

   //*******************************************************************
   // Wake-up detector
   //*******************************************************************
   // tick every divisor plus one cycles
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         pre <= 8'h0;
      else if (pre >= wdiv)
         pre <= 8'h0;
      else
         pre <= pre + 8'h1;
   end
   assign tick = (pre >= wdiv);

   // A dominant phase is a candidate; a zero filter time disables it
   // restart per candidate
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wstate <= W_IDLE;
         wcnt <= '0;
      end
      else
      begin
         case (wstate)
            W_IDLE:
            begin
               if (!core_rx && wft != 16'h0)
               begin
                  wstate <= W_DOM;
                  wcnt <= '0;
               end
            end
            W_DOM:
            begin
               if (core_rx)
                  wstate <= W_IDLE;
               else if (tick && wcnt != '1)
                  wcnt <= wcnt + 1'b1;
            end
            default: wstate <= W_IDLE;
         endcase
      end
   end

   assign wake_active = (wstate == W_DOM) && (wcnt >= 20'(wft));

   // Judge the pattern when the bus goes recessive again
   // expire check
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_event <= 1'b0;
         ev <= '0;
      end
      else
      begin
         wake_event <= wake_active && core_rx && (wcnt < wet);
         ev.wake <= wake_active && core_rx && (wcnt < wet);
         ev.expire <= (wstate == W_DOM) && core_rx && (wcnt >= wet);
         ev.aperr <= arb_err && !reset_mode;
      end
   end

   //*******************************************************************
   // Interrupts
   //*******************************************************************
   // Sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ists <= '0;
         imask <= '0;
      end
      else
      begin
         if (wr_en && hit(avs_address, `CTW_IDX_ISTS))
            ists <= (ists & ~avs_writedata[2:0]) | ev;
         else
            ists <= ists | ev;
         if (wr_en && hit(avs_address, `CTW_IDX_IMASK))
            imask <= avs_writedata[2:0];
      end
   end
   assign irq = |(ists & imask);

   //*******************************************************************
   // Assertions
   //*******************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_wait;
      req && avs_waitrequest;
   endsequence
   sequence s_dom_end;
      wstate == W_DOM && core_rx;
   endsequence

   a_bus_answer: assert property (s_wait |=> !avs_waitrequest)
      else $error("bus request not answered in one wait state");
   a_aperr_count: assert property (arb_err && !reset_mode &&
      aperr != 8'hff |=> aperr == $past(aperr) + 8'h1)
      else $error("arbitration error count did not advance");
   a_aperr_clear: assert property (reset_mode |=> aperr == 8'h0)
      else $error("arbitration error count not cleared");
   a_aperr_sat: assert property (aperr == 8'hff && !reset_mode
      |=> aperr == 8'hff)
      else $error("arbitration error count wrapped");
   a_tx_recessive: assert property (test_mode.txc |=> can_tx)
      else $error("transmit pin not recessive when disconnected");
   a_tx_follow: assert property (!test_mode.txc
      |=> can_tx == $past(core_tx))
      else $error("transmit pin does not follow transmitter");
   a_loop_route: assert property (test_mode.lben
      |=> core_rx == $past(core_tx))
      else $error("loopback did not route transmit to receive");
   a_test_lock: assert property (!reset_mode |=> $stable(test_mode))
      else $error("test bits changed outside reset mode");
   a_thr_lock: assert property (!reset_mode
      |=> $stable(wft) && $stable(wet))
      else $error("wake-up thresholds changed outside reset mode");
   // The divisor may be rewritten at any edge, so it must hold throughout
   a_tick_gap: assert property (tick && wdiv == 8'h1
      ##1 (wdiv == 8'h1) [*2] |-> tick && !$past(tick))
      else $error("prescaler tick period wrong");
   a_wake_valid: assert property (s_dom_end ##1 wake_event
      |-> $past(wcnt) < wet && $past(wcnt) >= 20'(wft))
      else $error("wake-up reported outside filter and expire window");
   a_wake_restart: assert property (wstate == W_IDLE &&
      !core_rx && wft != 16'h0 |=> wstate == W_DOM && wcnt == '0)
      else $error("wake-up count did not restart");
   a_rx_mult4: assert property (rxcnt[1:0] == 2'b00)
      else $error("receive byte count not a multiple of four");
   a_rx_clear: assert property (reset_mode |=> rxcnt == '0)
      else $error("receive byte count not cleared");
   a_rx_dec: assert property (rx_read && !rx_push && !reset_mode &&
      rxcnt != '0 |=> rxcnt == $past(rxcnt) - CNT_W'(4))
      else $error("receive byte count not lowered after read");

   // Word entries raise the count by one step, wrapping like the counter
   a_rx_inc: assert property (rx_push && !rx_read && !reset_mode
      |=> rxcnt == $past(rxcnt) + CNT_W'(4))
      else $error("receive byte count not raised by one word");

   // A dominant phase ending at or past the expire time must set the expire status
   a_wake_expire: assert property (s_dom_end ##0 (wcnt >= wet)
      |-> ##2 ists.expire)
      else $error("expired wake-up pattern not flagged");
   a_wake_pulse: assert property (wake_event |=> !wake_event)
      else $error("wake-up pulse longer than one cycle");
   a_wake_off: assert property (wstate == W_IDLE &&
      wft == 16'h0 |=> wstate == W_IDLE)
      else $error("wake-up detector armed with zero filter time");

   // Status bits stay set until software writes a one to them
   a_ists_sticky: assert property (!(wr_en &&
      hit(avs_address, `CTW_IDX_ISTS))
      |=> (ists & $past(ists)) == $past(ists))
      else $error("status bit lost without a clear");
   a_irq_raise: assert property ((|(ev & imask)) &&
      !(wr_en && hit(avs_address, `CTW_IDX_IMASK)) |=> irq)
      else $error("unmasked event did not raise the interrupt");
endmodule : ctw_top
`default_nettype wire

// >>> ctw_xcvr_model.sv
// Transceiver model: wired-AND bus seen through the receive pin
`timescale 1ns/10ps
`default_nettype none
module ctw_xcvr_model (
   input wire logic can_tx,
   input wire logic bus_dom,
   output logic can_rx
);
   // Any node driving dominant (0) wins; recessive only when all release
   assign can_rx = can_tx & ~bus_dom;
endmodule : ctw_xcvr_model
`default_nettype wire

// >>> can_test_wakeup_counters_bench.sv
// Self-checking bench for the test, wake-up and counter block
`timescale 1ns/10ps
`default_nettype none
`include "ctw_regs.svh"
module can_test_wakeup_counters_bench;
   import ctw_pkg::*;
   logic mclk, resetn, avs_read, avs_write, arb_err, core_tx;
   logic rx_push, rx_read, bus_dom, core_rx, can_tx, can_rx;
   logic wake_active, wake_event, reset_mode, irq, avs_waitrequest;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   ctw_test_t test_mode;
   int n_errors, n_checks, n_wake;
   ctw_top ctw_top_inst (.mclk(mclk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .arb_err(arb_err), .core_tx(core_tx), .core_rx(core_rx),
      .can_tx(can_tx), .can_rx(can_rx), .rx_push(rx_push),
      .rx_read(rx_read), .wake_active(wake_active),
      .wake_event(wake_event), .reset_mode(reset_mode),
      .test_mode(test_mode), .irq(irq));
   ctw_xcvr_model ctw_xcvr_model_inst (.can_tx(can_tx),
      .bus_dom(bus_dom), .can_rx(can_rx));
   //******************************************************************
   // Clock, event counting and helpers
   //******************************************************************
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Count wake-up pulses; one cycle wide, so one count each
   always @(posedge mclk)
   begin
      if (wake_event === 1'b1) n_wake <= n_wake + 1;
   end
   task print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
         n_errors++;
      end
   endtask : chk
   // Avalon master: hold request until waitrequest is sampled low
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      for (i = 0; i < 20; i++)
      begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (i == 20)
      begin
         $display("mismatch at %0t: bus request never answered", $time);
         n_errors++;
         print_verdict();
      end
   endtask : bus
   task wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rdc(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc
   // Hold an event input high for n edges, one event seen per edge
   task ev(input int which, input int n);
      @(posedge mclk);
      arb_err <= (which == 0);
      rx_push <= (which == 1);
      rx_read <= (which == 2);
      repeat (n) @(posedge mclk);
      arb_err <= 1'b0;
      rx_push <= 1'b0;
      rx_read <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : ev
   // Dominant bus phase of n cycles, then room for the pulse to land;
   // act is the filter level expected just before the bus goes recessive
   task dom(input int n, input logic act);
      @(posedge mclk);
      bus_dom <= 1'b1;
      repeat (n) @(posedge mclk);
      chk(32'(wake_active), 32'(act));
      bus_dom <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : dom
   //******************************************************************
   // Scenarios
   //******************************************************************
   task t_reset();
      rdc(`CTW_IDX_APERR, 32'h0);
      rdc(`CTW_IDX_TEST, 32'h0);
      rdc(`CTW_IDX_WDIV, 32'h0);
      rdc(`CTW_IDX_WFT, 32'h0);
      rdc(`CTW_IDX_WET, 32'h0);
      rdc(`CTW_IDX_RXCNT, 32'h0);
      rdc(6'h3f, 32'h0);
      rdc(`CTW_IDX_CTRL, 32'h1);
      wr(`CTW_IDX_RXCNT, 32'h55);
      rdc(`CTW_IDX_RXCNT, 32'h0);
   endtask : t_reset
   task t_test();
      wr(`CTW_IDX_TEST, 32'h3);
      rdc(`CTW_IDX_TEST, 32'h3);
      wr(`CTW_IDX_CTRL, 32'h0);
      wr(`CTW_IDX_TEST, 32'h0);
      rdc(`CTW_IDX_TEST, 32'h3);
      chk(32'(reset_mode), 32'h0);
      chk({30'h0, test_mode}, 32'h3);
      core_tx <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(32'(can_tx), 32'h1);
      chk(32'(core_rx), 32'h0);
      core_tx <= 1'b1;
      bus_dom <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(32'(core_rx), 32'h1);
      bus_dom <= 1'b0;
      wr(`CTW_IDX_CTRL, 32'h1);
      wr(`CTW_IDX_TEST, 32'h1);
      core_tx <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(32'(can_tx), 32'h0);
      core_tx <= 1'b1;
      wr(`CTW_IDX_TEST, 32'h0);
      wr(`CTW_IDX_CTRL, 32'h0);
   endtask : t_test
   task t_aperr();
      ev(0, 3);
      rdc(`CTW_IDX_APERR, 32'h3);
      wr(`CTW_IDX_IMASK, 32'h1);
      @(posedge mclk);
      chk(32'(irq), 32'h1);
      wr(`CTW_IDX_ISTS, 32'h1);
      @(posedge mclk);
      chk(32'(irq), 32'h0);
      ev(0, 260);
      rdc(`CTW_IDX_APERR, 32'hff);
      wr(`CTW_IDX_CTRL, 32'h1);
      rdc(`CTW_IDX_APERR, 32'h0);
      wr(`CTW_IDX_CTRL, 32'h0);
   endtask : t_aperr
   task t_rxcnt();
      ev(1, 3);
      rdc(`CTW_IDX_RXCNT, 32'hc);
      ev(2, 1);
      rdc(`CTW_IDX_RXCNT, 32'h8);
      ev(2, 5);
      rdc(`CTW_IDX_RXCNT, 32'h0);
      ev(1, 2);
      rdc(`CTW_IDX_RXCNT, 32'h8);
      wr(`CTW_IDX_CTRL, 32'h1);
      rdc(`CTW_IDX_RXCNT, 32'h0);
   endtask : t_rxcnt
   task t_wake();
      wr(`CTW_IDX_WDIV, 32'h1);
      wr(`CTW_IDX_WFT, 32'h4);
      wr(`CTW_IDX_WET, 32'ha);
      wr(`CTW_IDX_CTRL, 32'h0);
      wr(`CTW_IDX_WFT, 32'h9);
      rdc(`CTW_IDX_WFT, 32'h4);
      wr(`CTW_IDX_ISTS, 32'h7);
      n_wake = 0;
      dom(12, 1'b1);
      chk(32'(n_wake), 32'h1);
      dom(4, 1'b0);
      chk(32'(n_wake), 32'h1);
      dom(40, 1'b1);
      chk(32'(n_wake), 32'h1);
      rdc(`CTW_IDX_ISTS, 32'h6);
      wr(`CTW_IDX_CTRL, 32'h1);
      wr(`CTW_IDX_WDIV, 32'h7);
      wr(`CTW_IDX_CTRL, 32'h0);
      dom(12, 1'b0);
      chk(32'(n_wake), 32'h1);
   endtask : t_wake
   // Main sequence: reset, then each scenario in turn
   initial
   begin
      resetn = 1'b0;
      {avs_read, avs_write, arb_err, rx_push, rx_read, bus_dom} = 6'h0;
      core_tx = 1'b1;
      avs_address = 6'h0;
      avs_writedata = 32'h0;
      n_errors = 0;
      n_checks = 0;
      n_wake = 0;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset();
      t_test();
      t_aperr();
      t_rxcnt();
      t_wake();
      print_verdict();
   end
endmodule : can_test_wakeup_counters_bench
`default_nettype wire
